// >>> design/axis_servo_loop_control.sv
// five-axis position loop, feed supervision and reference-mark setup
//
// Operation
// - per-axis top programmable feed 1..65535, used as feed ceiling
// - per-axis rapid feed limit applied to rapid moves
// - arc feed capped at factor times radius over 85; zero lifts cap
// - any axis at 10 V applies override code/128; zero means none
// - feed outside 50..200 percent longer than code*10 ms raises error
// - below knee, command mV is low gain times error times 2.5/64
// - per-axis knee point 1..32767 selects where high gain takes over
// - above knee, low gain times knee plus high gain times excess
// - fixed-knee bit forces 256 micron knee on rapid and peak feed
// - released axis drops enable and stops closing loop at target
// - factor zero: drift past 16 times band raises following error
// - nonzero factor: drift past factor/2 times band re-enables axis
// - per-axis mark kind bit, regular or coded marks
// - coded mark fixed pitch bit, 20 mm or 100 mm
// - coded mark pitch growth direction bit
// - coded marks give absolute position within one fixed pitch move
// - scale zero offset added so position refers to machine home
// - per-axis home switch absent bit used by home search
// - per-axis home search direction bit
// - per-axis in-position band 0..255 microns
// - released axis drops enable in position; held axis keeps it
`timescale 1ns/1ns
`default_nettype none
module axis_servo_loop_control
  import servo_loop_pkg::*;
#(
  parameter int TICK_CYCLES = WINDOW_TICK_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [AXI_AW-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [AXI_AW-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic [N_AXES-1:0][23:0] pos_feedback_in,
  input wire logic [N_AXES-1:0][15:0] axis_speed_in,
  output logic [N_AXES-1:0][15:0] analog_cmd_out,
  output logic [N_AXES-1:0] axis_enable_out,
  output logic [N_AXES-1:0][31:0] abs_position_out,
  output home_cfg_t [N_AXES-1:0] home_cfg_out,
  output logic [N_AXES-1:0] following_error_out,
  output logic [N_AXES-1:0] feed_window_error_out,
  output logic [15:0] feed_limit_out
);

  function automatic logic axis_hit(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] rel;
    rel = a - AXIS_BASE;
    axis_hit = (a >= AXIS_BASE) && (32'(rel >> AXIS_SHIFT) < N_AXES)
      && (a[4:2] <= R_CMD);
  endfunction

  function automatic logic [2:0] axis_sel(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] rel;
    rel = a - AXIS_BASE;
    axis_sel = rel[AXIS_SHIFT+2:AXIS_SHIFT];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r & mask;
  endfunction

  function automatic logic [23:0] mag24(input logic [23:0] v);
    mag24 = v[23] ? 24'(-v) : v;
  endfunction

  function automatic logic [15:0] analog_mv(input logic [23:0] mag,
    input logic [7:0] k1, input logic [7:0] k2, input logic [14:0] knee);
    logic [39:0] acc;
    if (mag <= {9'h000, knee}) begin
      acc = 40'(k1) * 40'(mag);
    end else begin
      acc = 40'(k1) * 40'(knee)
        + 40'(k2) * 40'(mag - {9'h000, knee});
    end
    acc = (acc * GAIN_NUM) >> GAIN_SHIFT;
    analog_mv = (acc > 40'(SAT_MV)) ? SAT_MV : acc[15:0];
  endfunction

  // input synchronisers
  logic [N_AXES-1:0][23:0] pos_s1, pos_s2;
  logic [N_AXES-1:0][15:0] speed_s1, speed_s2;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_s1 <= '0;
      pos_s2 <= '0;
      speed_s1 <= '0;
      speed_s2 <= '0;
    end else if (ce_in) begin
      pos_s1 <= pos_feedback_in;
      pos_s2 <= pos_s1;
      speed_s1 <= axis_speed_in;
      speed_s2 <= speed_s1;
    end
  end

  // register and bus state
  logic [31:0] axis_reg [N_AXES][N_AXREG];
  logic [31:0] next_axis_reg [N_AXES][N_AXREG];
  logic [31:0] ctrl, next_ctrl, move, next_move, radius, next_radius;
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [AXI_AW-1:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic move_start;
  logic [N_AXES-1:0] clr_drift, clr_window;

  // loop state
  axis_state_t state [N_AXES];
  axis_state_t next_state [N_AXES];
  logic [7:0] win_cnt [N_AXES];
  logic [7:0] next_win_cnt [N_AXES];
  logic [N_AXES-1:0][15:0] next_cmd;
  logic [N_AXES-1:0] next_enable, next_drift_err, next_win_err, in_pos;
  logic [N_AXES-1:0][31:0] next_abs;
  home_cfg_t [N_AXES-1:0] next_home;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick;

  // feed limit
  logic [15:0] min_max, min_rapid, lim, next_feed_limit;
  logic [31:0] arc_lim;
  logic [23:0] eff;
  logic [7:0] ovr;
  logic sat_any, peak_move, fixed_knee;
  logic [1:0] kind;
  logic [15:0] req;

  always_comb begin
    kind = move[MOVE_KIND_LSB +: 2];
    req = move[MOVE_FEED_LSB +: 16];
    min_max = 16'hffff;
    min_rapid = 16'hffff;
    sat_any = 1'b0;
    for (int a = 0; a < N_AXES; a++) begin
      if (axis_reg[a][R_FEED][FEED_MAX_LSB +: 16] < min_max) begin
        min_max = axis_reg[a][R_FEED][FEED_MAX_LSB +: 16];
      end
      if (axis_reg[a][R_FEED][FEED_RAPID_LSB +: 16] < min_rapid) begin
        min_rapid = axis_reg[a][R_FEED][FEED_RAPID_LSB +: 16];
      end
      if (mag24({{8{analog_cmd_out[a][15]}}, analog_cmd_out[a]})
          >= 24'(SAT_MV)) begin
        sat_any = 1'b1;
      end
    end
    if (kind == MOVE_RAPID) begin
      lim = min_rapid;
    end else begin
      lim = (req < min_max) ? req : min_max;
    end
    arc_lim = (32'(ctrl[CTRL_ARC_LSB +: 8]) * 32'(radius[23:0]))
      / ARC_DIVISOR;
    if ((kind == MOVE_ARC) && (ctrl[CTRL_ARC_LSB +: 8] != 8'h00)
        && (arc_lim < 32'(lim))) begin
      lim = arc_lim[15:0];
    end
    ovr = OVR_FULL;
    if (sat_any && (ctrl[CTRL_OVR_LSB +: 8] != 8'h00)) begin
      ovr = ctrl[CTRL_OVR_LSB +: 8];
    end
    eff = (24'(lim) * 24'(ovr)) >> OVR_SHIFT;
    next_feed_limit = eff[15:0];
    peak_move = (kind == MOVE_RAPID) || (req >= min_max);
    fixed_knee = ctrl[CTRL_FIXKNEE_BIT] && peak_move;
    tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
  end

  // per-axis loop, drift and window supervision
  always_comb begin
    for (int a = 0; a < N_AXES; a++) begin
      logic [23:0] err, mag, band, drift_re, drift_err_lim;
      logic [14:0] knee;
      logic [15:0] mv;
      logic [7:0] factor, code;
      logic outside;
      err = axis_reg[a][R_TARGET][23:0] - pos_s2[a];
      mag = mag24(err);
      band = 24'(axis_reg[a][R_POS][POS_BAND_LSB +: 8]);
      factor = axis_reg[a][R_POS][POS_DRIFT_LSB +: 8];
      code = ctrl[CTRL_WIN_LSB +: 8];
      drift_err_lim = band << DRIFT_ERR_SHIFT;
      drift_re = (24'(factor) * band) >> 1;
      knee = fixed_knee ? FIXED_KNEE_UM
        : axis_reg[a][R_GAIN][GAIN_KNEE_LSB +: 15];
      mv = analog_mv(mag, axis_reg[a][R_GAIN][GAIN_K1_LSB +: 8],
        axis_reg[a][R_GAIN][GAIN_K2_LSB +: 8], knee);
      in_pos[a] = (mag <= band);
      next_state[a] = state[a];
      next_cmd[a] = 16'h0000;
      next_enable[a] = 1'b0;
      next_drift_err[a] = following_error_out[a] & ~clr_drift[a];
      next_win_err[a] = feed_window_error_out[a] & ~clr_window[a];
      next_win_cnt[a] = 8'h00;
      outside = (17'(speed_s2[a]) << 1) < 17'(eff)
        || (17'(speed_s2[a]) > (17'(eff) << 1));
      case (state[a])
        AX_IDLE: begin
          if (move_start) begin
            next_state[a] = AX_HOLD;
          end
        end
        AX_HOLD: begin
          next_enable[a] = 1'b1;
          next_cmd[a] = err[23] ? 16'(-mv) : mv;
          if (in_pos[a] && !axis_reg[a][R_POS][POS_HOLD_BIT]) begin
            next_state[a] = AX_FREE;
          end
          if (!in_pos[a] && (code != 8'h00) && outside) begin
            next_win_cnt[a] = win_cnt[a];
            if (tick) begin
              next_win_cnt[a] = (win_cnt[a] == 8'hff) ? 8'hff
                : win_cnt[a] + 8'h01;
              if (win_cnt[a] >= code) begin
                next_win_err[a] = 1'b1;
              end
            end
          end
        end
        AX_FREE: begin
          if (move_start) begin
            next_state[a] = AX_HOLD;
          end else if (factor == 8'h00) begin
            if (mag > drift_err_lim) begin
              next_drift_err[a] = 1'b1;
            end
          end else if (mag > drift_re) begin
            next_state[a] = AX_HOLD;
          end
        end
        default: begin
          next_state[a] = AX_IDLE;
        end
      endcase
      next_abs[a] = {{8{pos_s2[a][23]}}, pos_s2[a]}
        + axis_reg[a][R_ZERO];
      next_home[a].coded = axis_reg[a][R_POS][POS_CODED_BIT];
      next_home[a].pitch_neg = axis_reg[a][R_POS][POS_PITCHNEG_BIT];
      next_home[a].switch_absent =
        axis_reg[a][R_POS][POS_NOSWITCH_BIT];
      next_home[a].dir_neg = axis_reg[a][R_POS][POS_DIRNEG_BIT];
      next_home[a].search_um = axis_reg[a][R_POS][POS_PITCH_BIT]
        ? PITCH_100_UM : PITCH_20_UM;
    end
  end

  // axi4-lite slave
  always_comb begin
    logic [2:0] wa, ra;
    wa = axis_sel(waddr);
    ra = axis_sel(araddr_in);
    next_axis_reg = axis_reg;
    next_ctrl = ctrl;
    next_move = move;
    next_radius = radius;
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid_out && !bready_in;
    next_bresp = bresp_out;
    next_rvalid = rvalid_out && !rready_in;
    next_rresp = rresp_out;
    next_rdata = rdata_out;
    move_start = 1'b0;
    clr_drift = '0;
    clr_window = '0;
    if (awvalid_in && awready_out) begin
      next_aw_hold = 1'b1;
      next_waddr = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      next_w_hold = 1'b1;
      next_wdata = wdata_in;
      next_wstrb = wstrb_in;
    end
    if (aw_hold && w_hold && !bvalid_out) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (waddr[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2]) begin
        next_ctrl = merge(ctrl, wdata, wstrb, CTRL_MASK);
      end else if (waddr[AXI_AW-1:2] == MOVE_OFS[AXI_AW-1:2]) begin
        next_move = merge(move, wdata, wstrb, MOVE_MASK);
        move_start = 1'b1;
      end else if (waddr[AXI_AW-1:2] == RADIUS_OFS[AXI_AW-1:2]) begin
        next_radius = merge(radius, wdata, wstrb, RADIUS_MASK);
      end else if (waddr[AXI_AW-1:2] == GSTAT_OFS[AXI_AW-1:2]) begin
        next_bresp = RESP_OKAY;
      end else if (axis_hit(waddr)) begin
        if (waddr[4:2] == R_STAT) begin
          clr_drift[wa] = wstrb[0] & wdata[0];
          clr_window[wa] = wstrb[0] & wdata[1];
        end else if (waddr[4:2] != R_CMD) begin
          next_axis_reg[wa][waddr[4:2]] = merge(axis_reg[wa][waddr[4:2]],
            wdata, wstrb, AXREG_MASK[waddr[4:2]]);
        end
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (arvalid_in && arready_out) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (araddr_in[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2]) begin
        next_rdata = ctrl;
      end else if (araddr_in[AXI_AW-1:2] == MOVE_OFS[AXI_AW-1:2]) begin
        next_rdata = move;
      end else if (araddr_in[AXI_AW-1:2] == RADIUS_OFS[AXI_AW-1:2]) begin
        next_rdata = radius;
      end else if (araddr_in[AXI_AW-1:2] == GSTAT_OFS[AXI_AW-1:2]) begin
        next_rdata = {15'h0000, sat_any, feed_limit_out};
      end else if (axis_hit(araddr_in)) begin
        if (araddr_in[4:2] == R_STAT) begin
          next_rdata = {25'h0000000, state[ra], in_pos[ra],
            axis_enable_out[ra], feed_window_error_out[ra],
            following_error_out[ra]};
        end else if (araddr_in[4:2] == R_CMD) begin
          next_rdata = {{16{analog_cmd_out[ra][15]}}, analog_cmd_out[ra]};
        end else begin
          next_rdata = axis_reg[ra][araddr_in[4:2]];
        end
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int a = 0; a < N_AXES; a++) begin
        for (int r = 0; r < N_AXREG; r++) begin
          axis_reg[a][r] <= AXREG_RESET[r];
        end
        state[a] <= AX_IDLE;
        win_cnt[a] <= 8'h00;
        home_cfg_out[a] <= home_cfg_t'({4'h0, PITCH_20_UM});
      end
      ctrl <= CTRL_RESET;
      move <= MOVE_RESET;
      radius <= RADIUS_RESET;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      waddr <= '0;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OKAY;
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rresp_out <= RESP_OKAY;
      rdata_out <= 32'h0000_0000;
      tick_cnt <= 32'h0000_0000;
      analog_cmd_out <= '0;
      axis_enable_out <= '0;
      abs_position_out <= '0;
      following_error_out <= '0;
      feed_window_error_out <= '0;
      feed_limit_out <= 16'h0000;
    end else if (ce_in) begin
      axis_reg <= next_axis_reg;
      state <= next_state;
      win_cnt <= next_win_cnt;
      ctrl <= next_ctrl;
      move <= next_move;
      radius <= next_radius;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      awready_out <= next_awready;
      wready_out <= next_wready;
      bvalid_out <= next_bvalid;
      bresp_out <= next_bresp;
      arready_out <= next_arready;
      rvalid_out <= next_rvalid;
      rresp_out <= next_rresp;
      rdata_out <= next_rdata;
      tick_cnt <= next_tick_cnt;
      analog_cmd_out <= next_cmd;
      axis_enable_out <= next_enable;
      abs_position_out <= next_abs;
      home_cfg_out <= next_home;
      following_error_out <= next_drift_err;
      feed_window_error_out <= next_win_err;
      feed_limit_out <= next_feed_limit;
    end
  end

endmodule
`default_nettype wire

// >>> inc/servo_loop_pkg.sv
// constants, types and register map for the five-axis servo loop block
package servo_loop_pkg;
  localparam int N_AXES = 5;
  localparam int AXI_AW = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] MOVE_OFS = 12'h004;
  localparam logic [11:0] RADIUS_OFS = 12'h008;
  localparam logic [11:0] GSTAT_OFS = 12'h00c;
  localparam logic [11:0] AXIS_BASE = 12'h100;
  localparam int AXIS_SHIFT = 5;
  localparam int R_FEED = 0;
  localparam int R_GAIN = 1;
  localparam int R_POS = 2;
  localparam int R_ZERO = 3;
  localparam int R_TARGET = 4;
  localparam int N_AXREG = 5;
  localparam logic [2:0] R_STAT = 3'h5;
  localparam logic [2:0] R_CMD = 3'h6;
  localparam logic [31:0] AXREG_MASK [N_AXREG] = '{32'hffff_ffff,
    32'h7fff_ffff, 32'h003f_ffff, 32'hffff_ffff, 32'h00ff_ffff};
  localparam logic [31:0] AXREG_RESET [N_AXREG] = '{32'hffff_ffff,
    32'h03e8_2840, 32'h0001_000a, 32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] CTRL_MASK = 32'h01ff_ffff;
  localparam logic [31:0] MOVE_MASK = 32'h0003_ffff;
  localparam logic [31:0] RADIUS_MASK = 32'h00ff_ffff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MOVE_RESET = 32'h0000_0000;
  localparam logic [31:0] RADIUS_RESET = 32'h0000_0000;
  localparam int FEED_MAX_LSB = 0;
  localparam int FEED_RAPID_LSB = 16;
  localparam int GAIN_K1_LSB = 0;
  localparam int GAIN_K2_LSB = 8;
  localparam int GAIN_KNEE_LSB = 16;
  localparam int POS_BAND_LSB = 0;
  localparam int POS_DRIFT_LSB = 8;
  localparam int POS_HOLD_BIT = 16;
  localparam int POS_CODED_BIT = 17;
  localparam int POS_PITCH_BIT = 18;
  localparam int POS_PITCHNEG_BIT = 19;
  localparam int POS_NOSWITCH_BIT = 20;
  localparam int POS_DIRNEG_BIT = 21;
  localparam int CTRL_ARC_LSB = 0;
  localparam int CTRL_OVR_LSB = 8;
  localparam int CTRL_WIN_LSB = 16;
  localparam int CTRL_FIXKNEE_BIT = 24;
  localparam int MOVE_FEED_LSB = 0;
  localparam int MOVE_KIND_LSB = 16;
  localparam logic [1:0] MOVE_FEED = 2'h0;
  localparam logic [1:0] MOVE_RAPID = 2'h1;
  localparam logic [1:0] MOVE_ARC = 2'h2;
  localparam logic [14:0] FIXED_KNEE_UM = 15'h0100;
  localparam logic [15:0] SAT_MV = 16'h2710;
  localparam logic [7:0] OVR_FULL = 8'h80;
  localparam int OVR_SHIFT = 7;
  localparam int DRIFT_ERR_SHIFT = 4;
  localparam logic [31:0] ARC_DIVISOR = 32'h0000_0055;
  localparam logic [16:0] PITCH_20_UM = 17'h04e20;
  localparam logic [16:0] PITCH_100_UM = 17'h186a0;
  localparam logic [39:0] GAIN_NUM = 40'h5;
  localparam int GAIN_SHIFT = 7;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WINDOW_TICK_NS = 10_000_000;
  localparam int WINDOW_TICK_CYCLES = WINDOW_TICK_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    AX_IDLE = 3'b001,
    AX_HOLD = 3'b010,
    AX_FREE = 3'b100
  } axis_state_t;
  typedef struct packed {
    logic coded;
    logic pitch_neg;
    logic switch_absent;
    logic dir_neg;
    logic [16:0] search_um;
  } home_cfg_t;
endpackage

// >>> test/servo_drive_model.sv
// servo drive and scale model for five axes
`timescale 1ns/1ns
`default_nettype none
module servo_drive_model
  import servo_loop_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [N_AXES-1:0] enable_in,
  input wire logic load_valid_in,
  input wire logic [2:0] load_axis_in,
  input wire logic [23:0] load_pos_in,
  input wire logic [15:0] speed_set_in,
  output logic [N_AXES-1:0][23:0] pos_out,
  output logic [N_AXES-1:0][15:0] speed_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      pos_out <= '0;
    else if (load_valid_in)
      pos_out[load_axis_in] <= load_pos_in;
  end
  always_comb begin
    for (int a = 0; a < N_AXES; a++)
      speed_out[a] = enable_in[a] ? speed_set_in : 16'h0;
  end
endmodule
`default_nettype wire

// >>> test/servo_loop_asserts.sv
// bus and output checks for the servo loop block
`timescale 1ns/1ns
`default_nettype none
module servo_loop_asserts
  import servo_loop_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic [1:0] bresp_out,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic [N_AXES-1:0][15:0] analog_cmd_out,
  input wire logic [N_AXES-1:0] axis_enable_out,
  input wire home_cfg_t [N_AXES-1:0] home_cfg_out
);
  logic [N_AXES-1:0] cmd_nz;
  logic [N_AXES-1:0] cmd_over;
  logic [N_AXES-1:0] pitch_bad;
  always_comb begin
    for (int a = 0; a < N_AXES; a++) begin
      cmd_nz[a] = |analog_cmd_out[a];
      cmd_over[a] = analog_cmd_out[a][15] ? -analog_cmd_out[a] > SAT_MV
        : analog_cmd_out[a] > SAT_MV;
      pitch_bad[a] = home_cfg_out[a].search_um != PITCH_20_UM &&
        home_cfg_out[a].search_um != PITCH_100_UM;
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence wr_taken;
    ce_in && awvalid_in && awready_out && wvalid_in && wready_out;
  endsequence
  sequence resp_due;
    !bvalid_out ##1 bvalid_out;
  endsequence
  write_resp_a:
    assert property (wr_taken |=> resp_due) else $error("no bresp");
  read_resp_a:
    assert property (ce_in && arvalid_in && arready_out |=> rvalid_out)
      else $error("no rdata");
  read_hold_a:
    assert property (rvalid_out && !rready_in |=>
      rvalid_out && $stable(rdata_out)) else $error("rdata lost");
  write_hold_a:
    assert property (bvalid_out && !bready_in |=>
      bvalid_out && $stable(bresp_out)) else $error("bresp lost");
  read_block_a:
    assert property (rvalid_out |-> !arready_out)
      else $error("ar while busy");
  ready_return_a:
    assert property (ce_in && bvalid_out && bready_in |=>
      awready_out && wready_out) else $error("no wready");
  cmd_gate_a:
    assert property ((cmd_nz & ~axis_enable_out) == '0)
      else $error("cmd unheld");
  cmd_clamp_a:
    assert property (cmd_over == '0) else $error("cmd over");
  pitch_value_a:
    assert property (pitch_bad == '0) else $error("bad pitch");
endmodule
bind axis_servo_loop_control servo_loop_asserts servo_loop_asserts_inst (
  .clk_sys_in, .rst_n_in, .ce_in, .awvalid_in, .awready_out, .wvalid_in,
  .wready_out, .bresp_out, .bvalid_out, .bready_in, .arvalid_in,
  .arready_out, .rdata_out, .rvalid_out, .rready_in, .analog_cmd_out,
  .axis_enable_out, .home_cfg_out);
`default_nettype wire

// >>> test/axis_servo_loop_control_test.sv
// self-checking bench for the servo loop block
`timescale 1ns/1ns
`default_nettype none
module axis_servo_loop_control_test;
  import servo_loop_pkg::*;
  logic clk_sys_in, rst_n_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, load_valid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] load_axis;
  logic [23:0] load_pos;
  logic [15:0] speed_set, feed_lim;
  logic [N_AXES-1:0][23:0] pos_fb;
  logic [N_AXES-1:0][15:0] speed, cmd;
  logic [N_AXES-1:0][31:0] abs_pos;
  home_cfg_t [N_AXES-1:0] home;
  logic [N_AXES-1:0] en, ferr, werr;
  int n_errors = 0;
  int checked = 0;
  axis_servo_loop_control #(.TICK_CYCLES(10)) axis_servo_loop_control_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(1'h1),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'hf), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .pos_feedback_in(pos_fb),
    .axis_speed_in(speed), .analog_cmd_out(cmd), .axis_enable_out(en),
    .abs_position_out(abs_pos), .home_cfg_out(home),
    .following_error_out(ferr), .feed_window_error_out(werr),
    .feed_limit_out(feed_lim));
  servo_drive_model servo_drive_model_inst (.clk_in(clk_sys_in),
    .rst_n_in(rst_n_in), .enable_in(en), .load_valid_in(load_valid),
    .load_axis_in(load_axis), .load_pos_in(load_pos),
    .speed_set_in(speed_set), .pos_out(pos_fb), .speed_out(speed));
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task to_fail;
    n_errors++;
    end_sim();
  endtask
  task tk(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask
  task chk(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  function automatic logic [11:0] ax(input int a, input int r);
    return AXIS_BASE + 12'((a << AXIS_SHIFT) + (r << 2));
  endfunction
  task bus_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      tk(1);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid && n < 50);
    if (n >= 50) to_fail();
    rs = bresp;
    bready <= 1'h0;
    tk(8);
  endtask
  task bus_rd(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      tk(1);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (!rvalid && n < 50);
    if (n >= 50) to_fail();
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
    tk(1);
  endtask
  task set_pos(input logic [2:0] a, input logic [23:0] p);
    load_axis <= a;
    load_pos <= p;
    load_valid <= 1'h1;
    tk(1);
    load_valid <= 1'h0;
    tk(8);
  endtask
  task t_reset;
    for (int a = 0; a < N_AXES; a += 4) begin
      for (int r = 0; r < 3; r++) begin
        bus_rd(ax(a, r));
        chk("axreg", AXREG_RESET[r], rd);
      end
    end
    bus_rd(12'h080);
    chk("rresp", 32'(RESP_SLVERR), 32'(rs));
    bus_wr(12'h0f0, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(rs));
  endtask
  task t_feed;
    bus_wr(ax(0, R_FEED), 32'h04b0_012c);
    bus_wr(MOVE_OFS, 32'h1f4);
    chk("fcap", 32'h12c, 32'(feed_lim));
    bus_wr(MOVE_OFS, 32'hc8);
    chk("freq", 32'hc8, 32'(feed_lim));
    bus_wr(MOVE_OFS, 32'h1_00c8);
    chk("frap", 32'h4b0, 32'(feed_lim));
    bus_wr(ax(0, R_FEED), 32'hffff_ffff);
    bus_wr(RADIUS_OFS, 32'h3a98);
    bus_wr(CTRL_OFS, 32'h11);
    bus_wr(MOVE_OFS, 32'h2_1388);
    chk("farc", 32'hbb8, 32'(feed_lim));
    bus_wr(CTRL_OFS, 32'h0);
    bus_wr(MOVE_OFS, 32'h2_1388);
    chk("fnoarc", 32'h1388, 32'(feed_lim));
  endtask
  task t_gain;
    bus_wr(ax(0, R_TARGET), 32'h280);
    bus_wr(MOVE_OFS, 32'h64);
    chk("cmd1", 32'h640, 32'(cmd[0]));
    chk("en0", 32'h1, 32'(en[0]));
    bus_wr(ax(0, R_TARGET), 32'h7d0);
    chk("cmd2", 32'hfde, 32'(cmd[0]));
    bus_wr(ax(0, R_TARGET), 32'hff_f830);
    chk("cmd3", 32'hf022, 32'(cmd[0]));
    bus_wr(CTRL_OFS, 32'h100_0000);
    bus_wr(MOVE_OFS, 32'h1_0064);
    chk("knee256", 32'hf2db, 32'(cmd[0]));
    bus_wr(MOVE_OFS, 32'h64);
    chk("kneeusr", 32'hf022, 32'(cmd[0]));
    bus_wr(ax(0, R_TARGET), 32'h4_93e0);
    bus_wr(CTRL_OFS, 32'h4000);
    bus_wr(MOVE_OFS, 32'h3e8);
    chk("clamp", 32'(SAT_MV), 32'(cmd[0]));
    chk("ovr", 32'h1f4, 32'(feed_lim));
    bus_wr(CTRL_OFS, 32'h0);
    chk("noovr", 32'h3e8, 32'(feed_lim));
    bus_wr(ax(0, R_TARGET), 32'h7d0);
  endtask
  task t_drift;
    bus_wr(ax(1, R_POS), 32'ha);
    bus_wr(MOVE_OFS, 32'h64);
    chk("en1", 32'h0, 32'(en[1]));
    chk("en2", 32'h1, 32'(en[2]));
    set_pos(3'h1, 24'ha0);
    chk("cmd1off", 32'h0, 32'(cmd[1]));
    chk("drift160", 32'h0, 32'(ferr[1]));
    set_pos(3'h1, 24'ha1);
    chk("drift161", 32'h1, 32'(ferr[1]));
    set_pos(3'h1, 24'h0);
    bus_wr(ax(1, R_POS), 32'h40a);
    set_pos(3'h1, 24'h14);
    chk("rec20", 32'h0, 32'(en[1]));
    set_pos(3'h1, 24'h15);
    chk("rec21", 32'h1, 32'(en[1]));
    set_pos(3'h1, 24'h0);
    chk("refree", 32'h0, 32'(en[1]));
  endtask
  task t_home;
    bus_wr(ax(4, R_POS), 32'h3f_000a);
    bus_wr(ax(3, R_POS), 32'h2_000a);
    chk("home4", 32'({4'hf, PITCH_100_UM}),
      32'(home[4]));
    chk("home3", 32'({4'h8, PITCH_20_UM}),
      32'(home[3]));
    bus_wr(ax(4, R_ZERO), 32'h1000);
    set_pos(3'h4, 24'h100);
    chk("abs", 32'h1100, abs_pos[4]);
    set_pos(3'h4, 24'hff_fff0);
    chk("absneg", 32'hff0, abs_pos[4]);
  endtask
  task t_window;
    int n;
    n = 0;
    speed_set <= 16'h3e8;
    bus_wr(MOVE_OFS, 32'h3e8);
    bus_wr(CTRL_OFS, 32'h3_0000);
    tk(80);
    chk("win_in", 32'h0, 32'(werr[0]));
    speed_set <= 16'h7d1;
    while (werr[0] !== 1'h1 && n < 100) begin
      tk(1);
      n++;
    end
    chk("win_out", 32'h1, 32'(werr[0]));
    chk("win_wait", 32'h1, 32'(n >= 30));
  endtask
  initial begin
    clk_sys_in = 1'h0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    rst_n_in = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, load_valid} = '0;
    {awaddr, araddr, wdata, load_axis, load_pos, speed_set} = '0;
    tk(5);
    rst_n_in <= 1'h1;
    tk(2);
    t_reset();
    t_feed();
    t_gain();
    t_drift();
    t_home();
    t_window();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    to_fail();
  end
endmodule
`default_nettype wire
